// File: rtl/ccw_pkg.sv
package ccw_pkg;
   // serial register map (byte addresses on the serial port)
   localparam logic [5:0]  ADDR_WAVEFORM    = 6'h01;
   localparam logic [5:0]  ADDR_MODE        = 6'h09;
   localparam logic [5:0]  ADDR_IRQ_ENABLE  = 6'h0a;
   localparam logic [5:0]  ADDR_STATUS      = 6'h0b;
   localparam logic [5:0]  ADDR_STATUS_CLR  = 6'h0c;
   localparam logic [5:0]  ADDR_RMS_RESULT  = 6'h16;
   localparam logic [5:0]  ADDR_RMS_OFFSET  = 6'h18;
   // command byte layout
   localparam int          CMD_WRITE_BIT    = 7;
   // field positions
   localparam int          MODE_SRC_LO      = 13;
   localparam int          MODE_RATE_LO     = 11;
   localparam logic [1:0]  SRC_CURRENT      = 2'h2;
   localparam int          IRQ_SAMPLE_BIT   = 3;
   localparam int          STATUS_SAMPLE_BIT = 3;
   // reset values
   localparam logic [15:0] MODE_RST         = 16'h0000;
   localparam logic [15:0] IRQ_ENABLE_RST   = 16'h0000;
   localparam logic [11:0] RMS_OFFSET_RST   = 12'h000;
   // full-scale current codes, passed through unchanged
   localparam logic [23:0] FS_POS_CODE      = 24'h2851ec;
   localparam logic [23:0] FS_NEG_CODE      = 24'hd7ae14;
   localparam logic [23:0] FS_RMS_CODE      = 24'h1c82b3;
   // timing in master clock cycles, then filter shift amounts and the mean-square ceiling
   localparam int          WAVE_BASE_DIV    = 128;
   localparam int          RMS_UPDATE_DIV   = 4;
   localparam int          RMS_LPF_SHIFT    = 12;
   localparam int          OFFSET_WEIGHT_SH = 15;
   localparam logic [47:0] MEAN_SQ_MAX      = 48'hffffffffffff;

   typedef enum logic [1:0] {
      CCW_CMD,
      CCW_DATA,
      CCW_DONE
   } ccw_port_t;

   typedef struct packed {
      logic [23:0] word;
      logic        toggle;
   } ccw_link_t;

   typedef struct packed {
      logic [2:0]  cs_sync;
      logic [2:0]  sclk_sync;
      logic [1:0]  din_sync;
      logic [2:0]  tog_sync;
      logic [23:0] sample;
      logic [23:0] waveform;
      logic [15:0] mode;
      logic [15:0] irq_enable;
      logic [15:0] status;
      logic [11:0] rms_offset;
      logic [47:0] mean_sq;
      logic [23:0] rms_result;
      logic [10:0] rate_cnt;
      logic [1:0]  upd_cnt;
      ccw_port_t   pstate;
      logic [4:0]  bit_cnt;
      logic [4:0]  data_bits;
      logic [5:0]  addr;
      logic        write;
      logic [23:0] in_sr;
      logic [23:0] out_sr;
      logic        dout;
      logic        irq_hold;
   } ccw_sys_t;
endpackage

// File: rtl/ccw_current_channel.sv
`timescale 1ns/1ps
module ccw_current_channel
   import ccw_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        adc_clk,
   input  wire logic [23:0] adc_data,
   input  wire logic        adc_valid,
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        din,
   output logic             dout,
   output logic             dout_oe,
   input  wire logic        irq_n_in,
   output logic             irq_n_out,
   output logic             irq_n_oe
);

   ccw_link_t lnk;
   ccw_link_t next_lnk;
   ccw_sys_t  st;
   ccw_sys_t  next_st;

   // link side: hold the adc word, flag it with a toggle
   // the word stays still while only the one toggle bit crosses over
   always_comb begin
      next_lnk = lnk;
      if (adc_valid) begin
         next_lnk.word   = adc_data;
         next_lnk.toggle = ~lnk.toggle;
      end
   end

   always_ff @(posedge adc_clk or negedge rstn) begin
      if (!rstn) begin
         lnk <= '0;
      end else begin
         lnk <= next_lnk;
      end
   end

   // integer square root, one bit at a time
   // fully unrolled: large, but a fresh root is wanted every four clocks
   function automatic logic [23:0] ccw_isqrt(input logic [47:0] v);
      logic [23:0] root;
      logic [23:0] cand;
      logic [47:0] sq;
      root = '0;
      for (int i = 23; i >= 0; i--) begin
         cand = root | (24'h000001 << i);
         sq   = 48'(cand) * 48'(cand);
         if (sq <= v) begin
            root = cand;
         end
      end
      return root;
   endfunction

   // readable view of a register
   function automatic logic [23:0] ccw_read_val(input ccw_sys_t s,
                                                input logic [5:0] a);
      logic [23:0] v;
      v = '0;
      unique case (a)
         ADDR_WAVEFORM:   v = s.waveform;
         ADDR_MODE:       v = {8'h00, s.mode};
         ADDR_IRQ_ENABLE: v = {8'h00, s.irq_enable};
         ADDR_STATUS:     v = {8'h00, s.status};
         ADDR_STATUS_CLR: v = {8'h00, s.status};
         ADDR_RMS_RESULT: v = s.rms_result;
         ADDR_RMS_OFFSET: v = {12'h000, s.rms_offset};
         default:         v = '0;
      endcase
      return v;
   endfunction

   // transfer length in bits per register
   function automatic logic [4:0] ccw_len(input logic [5:0] a);
      logic [4:0] n;
      n = 5'd8;
      unique case (a)
         ADDR_WAVEFORM:   n = 5'd24;
         ADDR_RMS_RESULT: n = 5'd24;
         ADDR_MODE:       n = 5'd16;
         ADDR_IRQ_ENABLE: n = 5'd16;
         ADDR_STATUS:     n = 5'd16;
         ADDR_STATUS_CLR: n = 5'd16;
         ADDR_RMS_OFFSET: n = 5'd16;
         default:         n = 5'd8;
      endcase
      return n;
   endfunction

   logic               new_adc;
   logic               sclk_fall;
   logic               sclk_rise;
   logic               cs_active;
   logic               wave_tick;
   logic               capture;
   logic [15:0]        events;
   logic [47:0]        sq;
   logic signed [48:0] diff;
   logic signed [49:0] corr;
   logic [47:0]        corr_sat;
   logic [10:0]        rate_div;
   logic [7:0]         cmd;
   logic [23:0]        wdata;
   logic               clear_status;

   // edge and event decode from synchronised inputs
   always_comb begin
      new_adc   = st.tog_sync[2] ^ st.tog_sync[1];
      sclk_fall = st.sclk_sync[2] & ~st.sclk_sync[1];
      sclk_rise = ~st.sclk_sync[2] & st.sclk_sync[1];
      cs_active = ~st.cs_sync[1];
      // base divider doubled per rate code
      rate_div  = 11'(WAVE_BASE_DIV) << st.mode[MODE_RATE_LO +: 2];
      // at or past the end: a lower rate code must not wait for a wrap
      wave_tick = (st.rate_cnt >= rate_div - 11'd1);
      // route only current source with sampling enabled
      capture   = wave_tick
                & st.irq_enable[IRQ_SAMPLE_BIT]
                & (st.mode[MODE_SRC_LO +: 2] == SRC_CURRENT);
      events    = '0;
      events[STATUS_SAMPLE_BIT] = capture;
   end

   // mean-square low-pass and offset correction
   // 50 bits so that a signed offset can pull the sum below zero
   always_comb begin
      sq   = 48'($signed(st.sample) * $signed(st.sample));
      diff = $signed({1'b0, sq}) - $signed({1'b0, st.mean_sq});
      corr = $signed({2'b00, st.mean_sq})
           + ($signed(50'($signed(st.rms_offset))) <<< OFFSET_WEIGHT_SH);
      // clamp below zero and above the square-root range
      if (corr < 0) begin
         corr_sat = '0;
      end else if (corr > $signed({2'b00, MEAN_SQ_MAX})) begin
         corr_sat = MEAN_SQ_MAX;
      end else begin
         corr_sat = corr[47:0];
      end
   end

   // main state update
   always_comb begin
      next_st = st;
      cmd     = '0;
      wdata   = '0;
      clear_status = 1'b0;
      // pin and toggle synchronisers
      next_st.cs_sync   = {st.cs_sync[1:0], cs_n};
      next_st.sclk_sync = {st.sclk_sync[1:0], sclk};
      next_st.din_sync  = {st.din_sync[0], din};
      next_st.tog_sync  = {st.tog_sync[1:0], lnk.toggle};

      // latest adc word, taken after the toggle has settled
      // the word has stood two clocks or more when the toggle edge is seen
      if (new_adc) begin
         next_st.sample  = lnk.word;
         next_st.mean_sq = st.mean_sq + 48'(diff >>> RMS_LPF_SHIFT);
      end

      // averaging never pauses for waveform capture
      next_st.upd_cnt = st.upd_cnt + 2'd1;
      if (st.upd_cnt == 2'(RMS_UPDATE_DIV - 1)) begin
         next_st.rms_result = ccw_isqrt(corr_sat);
      end

      // waveform rate counter
      // eleven bits cover the slowest code, 1024 clocks per sample
      if (wave_tick) begin
         next_st.rate_cnt = '0;
      end else begin
         next_st.rate_cnt = st.rate_cnt + 11'd1;
      end
      // no settling gate; early words are left to the host to drop
      if (capture) begin
         next_st.waveform = st.sample;
      end

      // serial port
      // edges are seen through the synchronisers, so sclk must stay
      // at each level for three clocks or more
      if (!cs_active) begin
         // dout keeps its last bit; dout_oe alone releases the pin
         next_st.pstate   = CCW_CMD;
         next_st.bit_cnt  = '0;
         next_st.irq_hold = 1'b0;
      end else begin
         unique case (st.pstate)
            CCW_CMD: begin
               if (sclk_fall) begin
                  next_st.in_sr   = {st.in_sr[22:0], st.din_sync[1]};
                  next_st.bit_cnt = st.bit_cnt + 5'd1;
                  if (st.bit_cnt == 5'd7) begin
                     cmd = {st.in_sr[6:0], st.din_sync[1]};
                     next_st.write     = cmd[CMD_WRITE_BIT];
                     next_st.addr      = cmd[5:0];
                     next_st.data_bits = ccw_len(cmd[5:0]);
                     next_st.bit_cnt   = '0;
                     next_st.pstate    = CCW_DATA;
                     // left align so the msb leaves first
                     next_st.out_sr = ccw_read_val(st, cmd[5:0])
                                    << (5'd24 - ccw_len(cmd[5:0]));
                     // request held off for the whole data phase
                     if (!cmd[CMD_WRITE_BIT]
                         && cmd[5:0] == ADDR_STATUS_CLR) begin
                        clear_status     = 1'b1;
                        next_st.irq_hold = 1'b1;
                     end
                  end
               end
            end
            CCW_DATA: begin
               if (sclk_rise && !st.write) begin
                  next_st.dout   = st.out_sr[23];
                  next_st.out_sr = {st.out_sr[22:0], 1'b0};
               end
               if (sclk_fall) begin
                  next_st.in_sr   = {st.in_sr[22:0], st.din_sync[1]};
                  next_st.bit_cnt = st.bit_cnt + 5'd1;
                  if (st.bit_cnt == st.data_bits - 5'd1) begin
                     next_st.pstate   = CCW_DONE;
                     next_st.irq_hold = 1'b0;
                     if (st.write) begin
                        wdata = {st.in_sr[22:0], st.din_sync[1]};
                        unique case (st.addr)
                           ADDR_MODE:       next_st.mode = wdata[15:0];
                           ADDR_IRQ_ENABLE: next_st.irq_enable = wdata[15:0];
                           ADDR_RMS_OFFSET: begin
                              next_st.rms_offset = wdata[11:0];
                           end
                           default: begin
                              next_st.rms_offset = st.rms_offset;
                           end
                        endcase
                     end
                  end
               end
            end
            CCW_DONE: begin
               next_st.pstate = CCW_DONE;
            end
         endcase
      end

      // flags set only while their enable is on; a new event beats the clear
      // so a sample landing in the clearing cycle is never lost
      if (clear_status) begin
         next_st.status = events;
      end else begin
         next_st.status = st.status | events;
      end
   end

   // one register for all sys_clk state; reset parks chip select high
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st            <= '0;
         st.cs_sync    <= 3'h7;
         st.mode       <= MODE_RST;
         st.irq_enable <= IRQ_ENABLE_RST;
         st.rms_offset <= RMS_OFFSET_RST;
         st.pstate     <= CCW_CMD;
      end else begin
         st <= next_st;
      end
   end

   // pin drive: read data from the end of the command byte until deselect, request pulled only when pending
   // open drain: irq_n_out is fixed low and only the enable moves
   always_comb begin
      dout      = st.dout;
      dout_oe   = cs_active & (st.pstate != CCW_CMD) & ~st.write;
      irq_n_out = 1'b0;
      // enabled flags pull the line low
      irq_n_oe  = (|(st.status & st.irq_enable)) & ~st.irq_hold;
   end

endmodule // ccw_current_channel

// File: verification/ccw_current_channel_properties.sv
`timescale 1ns/1ps
module ccw_current_channel_properties (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        adc_clk,
   input wire logic [23:0] adc_data,
   input wire logic        adc_valid,
   input wire logic        cs_n,
   input wire logic        sclk,
   input wire logic        din,
   input wire logic        dout,
   input wire logic        dout_oe,
   input wire logic        irq_n_in,
   input wire logic        irq_n_out,
   input wire logic        irq_n_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic [7:0] gap;
   // cycles since the request last rose, saturating
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn) gap <= 8'hff;
      else if ($rose(irq_n_oe)) gap <= 8'h00;
      else if (gap != 8'hff) gap <= gap + 8'h01;
   // request pin, sample spacing and serial output timing
   property p_pin; irq_n_out == 1'b0; endproperty
   a_pin: assert property (p_pin) else $error("pin value");
   property p_hold; irq_n_oe && cs_n |=> irq_n_oe; endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   property p_clr; $fell(irq_n_oe) |-> !cs_n; endproperty
   a_clr: assert property (p_clr) else $error("drop outside read");
   property p_gap; $rose(irq_n_oe) |-> gap >= 8'h7f; endproperty
   a_gap: assert property (p_gap) else $error("samples too close");
   property p_idle; cs_n [*5] |-> !dout_oe; endproperty
   a_idle: assert property (p_idle) else $error("drive when idle");
   property p_rise; $rose(dout_oe) |-> !$past(cs_n, 16); endproperty
   a_rise: assert property (p_rise) else $error("early drive");
   property p_fall; $fell(dout_oe) |-> cs_n; endproperty
   a_fall: assert property (p_fall) else $error("drive cut short");
   property p_dout; !sclk [*5] |-> $stable(dout); endproperty
   a_dout: assert property (p_dout) else $error("data moved");
   c_sample: cover property ($rose(irq_n_oe));
   c_clear: cover property ($fell(irq_n_oe));
   c_read: cover property ($rose(dout_oe));
endmodule // ccw_current_channel_properties
bind ccw_current_channel ccw_current_channel_properties u_props (
   .sys_clk, .rstn, .adc_clk, .adc_data, .adc_valid, .cs_n, .sclk,
   .din, .dout, .dout_oe, .irq_n_in, .irq_n_out, .irq_n_oe);

// File: verification/ccw_host_model.sv
`timescale 1ns/1ps
module ccw_host_model
   import ccw_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic dout,
   output logic      cs_n,
   output logic      sclk,
   output logic      din
);
   // idle lines, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din  = 1'b0;
   end
   // one frame: command byte then n data bits, msb first both ways
   task automatic xfer(input logic [5:0] a, input logic wr, input int n,
                       input logic [23:0] wd, output logic [23:0] rd);
      logic [31:0] sr;
      if (wr && a == ADDR_RMS_OFFSET) wd[11] = 1'b0;
      sr = {wr, 1'b0, a, wd << (24 - n)};
      rd = 24'h0;
      @(negedge sys_clk) cs_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      for (int i = 0; i < 8 + n; i++) begin
         sclk = 1'b1;
         din  = sr[31];
         sr   = sr << 1;
         repeat (5) @(negedge sys_clk);
         if (i >= 8) rd = {rd[22:0], dout};
         sclk = 1'b0;
         repeat (4) @(negedge sys_clk);
      end
      repeat (2) @(negedge sys_clk);
      cs_n = 1'b1;
      din  = ~din; // released line shows no stale bit
      repeat (10) @(negedge sys_clk);
   endtask
endmodule // ccw_host_model

// File: verification/tb_ccw_current_channel.sv
`timescale 1ns/1ps
module tb_ccw_current_channel
   import ccw_pkg::*;
;
   logic        sys_clk, adc_clk, rstn, cs_n, sclk, din, dout;
   logic        dout_oe, irq_n_out, irq_n_oe;
   logic        adc_valid = 1'b0;
   logic [3:0]  adc_cnt   = 4'h0;
   logic [23:0] adc_data  = 24'h0;
   logic [23:0] adc_word  = 24'h0;
   int          err_total = 0;
   int          comparisons = 0;
   wire         irq_wire = irq_n_oe ? irq_n_out : 1'b1; // pull-up
   ccw_current_channel u_dut (.sys_clk(sys_clk), .rstn(rstn),
      .adc_clk(adc_clk), .adc_data(adc_data), .adc_valid(adc_valid),
      .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
      .dout_oe(dout_oe), .irq_n_in(irq_wire), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe));
   ccw_host_model u_host (.sys_clk(sys_clk), .dout(dout), .cs_n(cs_n),
      .sclk(sclk), .din(din));
   // clocks, link clock offset in phase
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      adc_clk = 1'b0;
      #7;
      forever #24 adc_clk = ~adc_clk;
   end
   // word source, one word every ten link cycles
   always @(negedge adc_clk) begin
      adc_cnt   <= (adc_cnt == 4'h9) ? 4'h0 : adc_cnt + 4'h1;
      adc_valid <= (adc_cnt == 4'h9);
      adc_data  <= adc_word;
   end
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [5:0] a, input int n,
                         input logic [23:0] e);
      logic [23:0] v;
      u_host.xfer(a, 1'b0, n, 24'h0, v);
      check(v, e);
   endtask
   task automatic wr(input logic [5:0] a, input int n, input logic [23:0] d);
      logic [23:0] v;
      u_host.xfer(a, 1'b1, n, d, v);
   endtask
   task automatic clr;
      logic [23:0] v;
      u_host.xfer(ADDR_STATUS_CLR, 1'b0, 16, 24'h0, v);
   endtask
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq_n_oe !== 1'b1) begin
         @(negedge sys_clk);
         n++;
         if (n > 4000) begin
            err_total++;
            $display("wrong value at %0t: no request", $time);
            end_sim();
         end
      end
   endtask
   function automatic logic [23:0] isqrt(input longint v);
      longint r;
      r = 0;
      while ((r + 1) * (r + 1) <= v) r++;
      return 24'(r);
   endfunction
   // reset values, unmapped read gives one zero byte
   task automatic t_reset;
      rd_chk(ADDR_MODE, 16, 24'(MODE_RST));
      rd_chk(ADDR_IRQ_ENABLE, 16, 24'(IRQ_ENABLE_RST));
      rd_chk(ADDR_RMS_OFFSET, 16, 24'(RMS_OFFSET_RST));
      rd_chk(6'h3f, 8, 24'h0);
   endtask
   // rms from the offset alone while words stay zero
   task automatic t_rms;
      int offs[2] = '{1, 2047};
      foreach (offs[i]) begin
         wr(ADDR_RMS_OFFSET, 16, 24'(offs[i]));
         repeat (20) @(negedge sys_clk);
         rd_chk(ADDR_RMS_RESULT, 24, isqrt(offs[i] * 32768));
      end
      rd_chk(ADDR_RMS_OFFSET, 16, 24'h0007ff);
      wr(ADDR_RMS_RESULT, 24, 24'h123456);
      rd_chk(ADDR_RMS_RESULT, 24, isqrt(2047 * 32768));
   endtask
   // no event unless enabled and routed to the current channel
   task automatic t_gate;
      wr(ADDR_IRQ_ENABLE, 16, 24'h0008);
      repeat (300) @(negedge sys_clk);
      rd_chk(ADDR_STATUS, 16, 24'h0);
      wr(ADDR_IRQ_ENABLE, 16, 24'h0);
      wr(ADDR_MODE, 16, 24'h4000);
      repeat (300) @(negedge sys_clk);
      rd_chk(ADDR_STATUS, 16, 24'h0);
   endtask
   // full-scale words captured, request held until the clearing read
   task automatic t_capture;
      logic [23:0] w[2] = '{FS_NEG_CODE, FS_POS_CODE};
      wr(ADDR_IRQ_ENABLE, 16, 24'h0008);
      foreach (w[i]) begin
         adc_word = w[i];
         repeat (1500) @(negedge sys_clk);
         wait_irq();
         rd_chk(ADDR_WAVEFORM, 24, w[i]);
         check({23'h0, irq_n_oe}, 24'h1);
         rd_chk(ADDR_STATUS_CLR, 16, 24'h0008);
      end
   endtask
   // code 00 outruns a clearing read, higher codes halve the rate
   task automatic t_rate;
      time t1;
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_MODE, 16, 24'(32'h4000 | (c << MODE_RATE_LO)));
         clr();
         for (int k = 0; k < 16 && irq_n_oe !== 1'b0; k++)
            clr();
         wait_irq();
         t1 = $time;
         clr();
         if (c == 0)
            check({23'h0, irq_n_oe}, 24'h1);
         else begin
            wait_irq();
            check(24'(($time - t1) / 100), 24'(WAVE_BASE_DIV << c));
         end
      end
   endtask
   // reset, then the scenarios in order
   initial begin
      rstn = 1'b0;
      repeat (20) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_reset();
      t_rms();
      t_gate();
      t_capture();
      t_rate();
      end_sim();
   end
endmodule // tb_ccw_current_channel
